// [core/pci_target_term.sv]
`default_nettype none
module pci_target_term (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic FRAME_N,
	input wire logic IRDY_N,
	input wire logic HIT,
	input wire logic IS_READ,
	input wire pci_term_pkg::backend_req_s BACKEND_REQ,
	input wire logic [31:0] LOCAL_READ_DATA,
	input wire logic [31:0] AD_IN,
	output pci_term_pkg::term_pins_s TERM_PINS,
	output logic TERM_OE,
	output logic [31:0] AD_O,
	output logic AD_OE,
	output logic LOCAL_TRANSFER_STROBE_N,
	output logic [31:0] LOCAL_WRITE_DATA
);
	import pci_term_pkg::*;

	term_state_e state, next_state;
	term_pins_s next_pins;
	backend_req_s prev_req;
	logic next_oe, next_ad_oe, next_strobe_n;
	logic is_read, next_is_read;
	logic seen_ready, next_seen_ready;
	logic retry, next_retry;
	logic [4:0] wait_cnt, next_wait_cnt;
	logic [31:0] next_ad, next_wr_data;
	logic disc_held, timed_out, phase_done;

	// ==================================================
	// request history
	req_history u_hist (
		.clk(REF_CLK),
		.rst(RST),
		.req(BACKEND_REQ),
		.prev(prev_req)
	);

	// disconnect low this clock and the one before
	assign disc_held = !BACKEND_REQ.backend_disconnect_req_n &&
		!prev_req.backend_disconnect_req_n;
	// still no ready on the last allowed clock
	assign timed_out = (wait_cnt == READY_TIMEOUT_CLKS - CNT_ONE) &&
		!seen_ready && BACKEND_REQ.backend_ready_n;
	assign phase_done = !TERM_PINS.trdy_n && !IRDY_N;

	// ==================================================
	// next-state logic
	always_comb begin
		next_state = state;
		next_pins = TERM_PINS;
		next_oe = TERM_OE;
		next_is_read = is_read;
		next_seen_ready = seen_ready;
		next_retry = retry;
		next_wait_cnt = wait_cnt;
		next_strobe_n = PIN_HIGH;
		next_ad = AD_O;
		next_wr_data = LOCAL_WRITE_DATA;
		case (state)
			ST_IDLE: begin
				next_pins = PINS_RELEASED;
				next_oe = 1'b0;
				if (!FRAME_N && HIT) begin
					next_state = ST_ACTIVE;
					next_pins.devsel_n = 1'b0;
					next_oe = 1'b1;
					next_is_read = IS_READ;
					next_seen_ready = 1'b0;
					next_retry = 1'b0;
					next_wait_cnt = CNT_ZERO;
				end
			end
			ST_ACTIVE, ST_STOP: begin
				if (wait_cnt != READY_TIMEOUT_CLKS) begin
					next_wait_cnt = wait_cnt + CNT_ONE;
				end
				if (!BACKEND_REQ.backend_ready_n) begin
					next_seen_ready = 1'b1;
				end
				// data path: read trdy two clocks, write one clock after ready
				if (is_read) begin
					next_pins.trdy_n = prev_req.backend_ready_n;
					next_strobe_n = BACKEND_REQ.backend_ready_n;
					if (!LOCAL_TRANSFER_STROBE_N &&
							BACKEND_REQ.backend_abort_req_n) begin
						next_ad = LOCAL_READ_DATA;
					end
				end else begin
					next_pins.trdy_n = BACKEND_REQ.backend_ready_n;
					next_strobe_n = !phase_done;
					if (phase_done) begin
						next_wr_data = AD_IN;
					end
				end
				if (retry) begin
					next_pins.trdy_n = PIN_HIGH;
				end
				if (state == ST_ACTIVE) begin
					if (!BACKEND_REQ.backend_abort_req_n) begin
						// abort wins and ignores irdy
						next_state = ST_ABORT;
						next_pins = '{devsel_n: 1'b1, trdy_n: 1'b1,
							stop_n: 1'b0};
					end else if ((disc_held || timed_out) &&
							!seen_ready) begin
						next_state = ST_STOP;
						next_retry = 1'b1;
						next_pins.stop_n = 1'b0;
						next_pins.trdy_n = PIN_HIGH;
					end else if (disc_held) begin
						next_state = ST_STOP;
						next_pins.stop_n = 1'b0;
					end
				end else if (FRAME_N) begin
					// last phase under stop: release once frame is high, irdy not looked at
					next_state = ST_RELEASE;
					next_pins = PINS_RELEASED;
				end
			end
			ST_ABORT: begin
				if (FRAME_N) begin
					next_state = ST_RELEASE;
					next_pins.stop_n = PIN_HIGH;
				end
			end
			ST_RELEASE: begin
				// pins were high one clock, now turn off
				next_state = ST_IDLE;
				next_oe = 1'b0;
			end
			default: begin
				next_state = ST_IDLE;
				next_pins = PINS_RELEASED;
				next_oe = 1'b0;
			end
		endcase
		next_ad_oe = (next_state == ST_ACTIVE || next_state == ST_STOP) &&
			next_is_read;
	end

	// ==================================================
	// state registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state <= ST_IDLE;
			TERM_PINS <= PINS_RELEASED;
			TERM_OE <= 1'b0;
			AD_OE <= 1'b0;
			AD_O <= DATA_RESET;
			LOCAL_TRANSFER_STROBE_N <= PIN_HIGH;
			LOCAL_WRITE_DATA <= DATA_RESET;
			is_read <= 1'b0;
			seen_ready <= 1'b0;
			retry <= 1'b0;
			wait_cnt <= CNT_ZERO;
		end else begin
			state <= next_state;
			TERM_PINS <= next_pins;
			TERM_OE <= next_oe;
			AD_OE <= next_ad_oe;
			AD_O <= next_ad;
			LOCAL_TRANSFER_STROBE_N <= next_strobe_n;
			LOCAL_WRITE_DATA <= next_wr_data;
			is_read <= next_is_read;
			seen_ready <= next_seen_ready;
			retry <= next_retry;
			wait_cnt <= next_wait_cnt;
		end
	end

	// ==================================================
	// checks
	// all checks sample on the bus clock and sleep during reset
	default clocking chk_clk @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	chk_retry_cause: assert property (
		($fell(TERM_PINS.stop_n) && $past(state) == ST_ACTIVE &&
			$past(BACKEND_REQ.backend_abort_req_n) && !$past(timed_out))
		|-> !$past(BACKEND_REQ.backend_disconnect_req_n) &&
			!$past(BACKEND_REQ.backend_disconnect_req_n, 2))
		else $error("stop without two clocks of disconnect");
	chk_retry_no_trdy: assert property (
		(state == ST_STOP && retry) |-> TERM_PINS.trdy_n)
		else $error("trdy asserted during retry");
	chk_strobe_idle: assert property (
		($past(state) == ST_ACTIVE && is_read &&
			$past(BACKEND_REQ.backend_ready_n)) |-> LOCAL_TRANSFER_STROBE_N)
		else $error("strobe after ready high");
	chk_strobe_follow: assert property (
		($past(state) == ST_ACTIVE && is_read &&
			!$past(BACKEND_REQ.backend_ready_n)) |-> !LOCAL_TRANSFER_STROBE_N)
		else $error("strobe missing after ready");
	chk_read_trdy: assert property (
		($past(state) == ST_ACTIVE && is_read &&
			$past(BACKEND_REQ.backend_abort_req_n))
		|-> TERM_PINS.trdy_n == $past(BACKEND_REQ.backend_ready_n, 2))
		else $error("read trdy not two clocks after ready");
	chk_abort_answer: assert property (
		(state == ST_ACTIVE && !BACKEND_REQ.backend_abort_req_n)
		|=> TERM_PINS.devsel_n && TERM_PINS.trdy_n && !TERM_PINS.stop_n)
		else $error("abort not signalled next clock");
	chk_abort_hold: assert property (
		(state == ST_ABORT && !FRAME_N) |=> !TERM_PINS.stop_n && TERM_OE)
		else $error("abort stop dropped early");
	chk_abort_end: assert property (
		(state == ST_ABORT && FRAME_N) |=> TERM_PINS.stop_n ##1 !TERM_OE)
		else $error("abort stop not released");
	chk_retry_end: assert property (
		(state == ST_STOP && FRAME_N)
		|=> TERM_PINS.devsel_n && TERM_PINS.stop_n)
		else $error("devsel or stop held after master end");
	chk_release_high: assert property (
		(state == ST_RELEASE) |-> TERM_OE && TERM_PINS == PINS_RELEASED
			##1 !TERM_OE)
		else $error("pins not driven high before release");
	chk_timeout_retry: assert property (
		(state == ST_ACTIVE && timed_out &&
			BACKEND_REQ.backend_abort_req_n)
		|=> !TERM_PINS.stop_n && TERM_PINS.trdy_n && retry)
		else $error("no retry after timeout");
	chk_abort_data: assert property (
		(is_read && !LOCAL_TRANSFER_STROBE_N &&
			!BACKEND_REQ.backend_abort_req_n) |=> AD_O == $past(AD_O))
		else $error("data taken with abort");
endmodule // pci_target_term
`default_nettype wire

// [core/req_history.sv]
`default_nettype none
// one-clock history of the back-end requests
module req_history (
	input wire logic clk,
	input wire logic rst,
	input wire pci_term_pkg::backend_req_s req,
	output pci_term_pkg::backend_req_s prev
);
	import pci_term_pkg::*;

	backend_req_s next_prev;

	// ==================================================
	// history register
	always_comb begin
		next_prev = req;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev <= REQ_IDLE;
		end else begin
			prev <= next_prev;
		end
	end
endmodule // req_history
`default_nettype wire

// [pkg/pci_term_pkg.sv]
`default_nettype none
package pci_term_pkg;
	// ==================================================
	// widths and timing
	localparam int DATA_W = 32;
	localparam int CNT_W = 5;
	// clocks from selection before an unready back-end forces a retry
	localparam logic [4:0] READY_TIMEOUT_CLKS = 5'h10;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	// level of a released active-low pin
	localparam logic PIN_HIGH = 1'b1;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// ==================================================
	// carriers
	// active-low target termination pins
	typedef struct packed {
		logic devsel_n;
		logic trdy_n;
		logic stop_n;
	} term_pins_s;

	// active-low back-end handshake requests
	typedef struct packed {
		logic backend_ready_n;
		logic backend_disconnect_req_n;
		logic backend_abort_req_n;
	} backend_req_s;

	localparam term_pins_s PINS_RELEASED = 3'h7;
	localparam backend_req_s REQ_IDLE = 3'h7;

	// ==================================================
	// termination sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ACTIVE = 5'b00010,
		ST_STOP = 5'b00100,
		ST_ABORT = 5'b01000,
		ST_RELEASE = 5'b10000
	} term_state_e;
endpackage
`default_nettype wire

// [testbench/pci_master_model.sv]
`default_nettype none
// behavioural bus master: selects, then backs off once stop is seen
module pci_master_model (
	input wire logic clk,
	input wire logic go,
	input wire logic lazy,
	input wire pci_term_pkg::term_pins_s pins,
	output logic frame_n,
	output logic irdy_n,
	output logic hit
);
	timeunit 1ns;
	timeprecision 1ps;
	import pci_term_pkg::*;
	logic stop_seen = 1'b0;
	// stop is taken at the rising edge, as a bus master samples it
	always @(posedge clk) begin
		stop_seen <= !pins.stop_n;
	end
	// bus lines idle high, as the pull-ups leave them
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		hit = 1'b0;
	end
	// changes land just after the falling edge
	always @(negedge clk) begin
		hit <= go;
		if (go) begin
			frame_n <= 1'b0;
			irdy_n <= lazy; // lazy keeps irdy high throughout
		end else if (!frame_n && stop_seen) begin
			frame_n <= 1'b1;
		end else if (frame_n && !irdy_n) begin
			irdy_n <= 1'b1;
		end
	end
endmodule // pci_master_model
`default_nettype wire

// [testbench/tb_pci_target_retry_abort.sv]
`default_nettype none
// random rounds of retry, timeout retry and read abort
module tb_pci_target_retry_abort;
	timeunit 1ns;
	timeprecision 1ps;
	import pci_term_pkg::*;
	logic ref_clk, rst, go, lazy, is_read, frame_n, irdy_n, hit;
	logic oe, ad_oe, strobe_n;
	logic [31:0] rd_data, ad_in, ad_o, wr_data, d1;
	logic [15:0] seed;
	backend_req_s req;
	term_pins_s pins, bus_pins;
	int failures, total_checks, k;
	// ==================================================
	// wiring
	assign bus_pins = oe ? pins : PINS_RELEASED; // pulled up when off
	pci_target_term dut (.REF_CLK(ref_clk), .RST(rst), .FRAME_N(frame_n),
		.IRDY_N(irdy_n), .HIT(hit), .IS_READ(is_read), .BACKEND_REQ(req),
		.LOCAL_READ_DATA(rd_data), .AD_IN(ad_in), .TERM_PINS(pins),
		.TERM_OE(oe), .AD_O(ad_o), .AD_OE(ad_oe),
		.LOCAL_TRANSFER_STROBE_N(strobe_n), .LOCAL_WRITE_DATA(wr_data));
	pci_master_model master (.clk(ref_clk), .go(go), .lazy(lazy),
		.pins(bus_pins), .frame_n(frame_n), .irdy_n(irdy_n), .hit(hit));
	// ==================================================
	// helpers
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cyc();
		@(negedge ref_clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// master selects; devsel answers one cycle later
	task automatic select();
		go <= 1'b1;
		cyc();
		go <= 1'b0;
		cyc();
		check(32'(pins.devsel_n), 32'h0);
		check(32'(oe), 32'h1);
	endtask
	// pins driven high one cycle, then let go
	task automatic release_bus();
		req <= REQ_IDLE;
		cyc();
		check(32'(pins.stop_n), 32'h0);
		cyc();
		check(32'(pins), 32'(PINS_RELEASED));
		check(32'(oe), 32'h1);
		cyc();
		check(32'(oe), 32'h0);
	endtask
	// ==================================================
	// scenarios
	task automatic retry_disc();
		is_read <= seed[1];
		lazy <= 1'b0;
		select();
		req <= 3'b101;
		cyc();
		check(32'(pins.stop_n), 32'h1);
		cyc();
		check(32'(pins), 32'h2);
		release_bus();
	endtask
	task automatic retry_timeout();
		is_read <= seed[2];
		select();
		k = 1;
		while (pins.stop_n !== 1'b0 && k < 40) begin
			check(32'(pins.trdy_n), 32'h1);
			cyc();
			k++;
		end
		if (pins.stop_n !== 1'b0) begin
			failures++;
			report_and_stop();
		end
		check(32'(k >= 15 && k <= 17), 32'h1);
		release_bus();
	endtask
	task automatic read_abort();
		lazy <= seed[0];
		is_read <= 1'b1;
		select();
		req <= 3'b011;
		cyc();
		check(32'(strobe_n), 32'h0);
		check(32'(ad_oe), 32'h1);
		d1 = {seed, ~seed};
		rd_data <= d1;
		cyc();
		check(32'(pins.trdy_n), 32'h0);
		check(ad_o, d1);
		check(32'(strobe_n), 32'h0);
		req <= 3'b110;
		rd_data <= ~d1;
		cyc();
		check(32'(pins), 32'h6);
		check(ad_o, d1);
		check(32'(strobe_n), 32'h1);
		release_bus();
	endtask
	// one write phase, then a disconnect after data
	task automatic write_disc();
		is_read <= 1'b0;
		lazy <= 1'b0;
		select();
		req <= 3'b011;
		cyc();
		check(32'(pins.trdy_n), 32'h0);
		check(32'(ad_oe), 32'h0);
		req <= 3'b101;
		cyc();
		check(32'(strobe_n), 32'h0);
		check(wr_data, ad_in);
		cyc();
		check(32'(pins), 32'h2);
		check(32'(strobe_n), 32'h1);
		release_bus();
	endtask
	// ==================================================
	// main sequence
	initial begin
		rst = 1'b1;
		go = 1'b0;
		lazy = 1'b0;
		is_read = 1'b0;
		req = REQ_IDLE;
		rd_data = 32'h0;
		ad_in = 32'h0;
		seed = 16'h3bad;
		failures = 0;
		total_checks = 0;
		repeat (12) cyc();
		rst <= 1'b0;
		cyc();
		check(32'(pins), 32'(PINS_RELEASED));
		check(32'({oe, ad_oe, strobe_n}), 32'h1);
		for (int r = 0; r < 6; r++) begin
			seed = lfsr(seed);
			ad_in <= {~seed, seed};
			retry_disc();
			retry_timeout();
			read_abort();
			write_disc();
		end
		report_and_stop();
	end
endmodule // tb_pci_target_retry_abort
`default_nettype wire
